// ---- bench/emad_asserts.sv ----
// Checker watching the link between the decoder and the outside master
`timescale 1ns/1ps
module emad_asserts
(
	// Clock, reset and arbitration
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic bus_granted_away_i,
	input wire logic explicit_own_i,
	input wire logic busy_o,
	// Link signals
	input wire logic transfer_start_n,
	input wire logic rd_wr,
	input wire logic [1:0] transfer_size,
	input wire logic wdata_oe,
	input wire logic transfer_ack_n,
	input wire logic transfer_ack_n_oe,
	input wire logic [7:0] cs_n,
	input wire logic [3:0] we_n,
	input wire logic [1:0] ras_n,
	input wire logic dram_addr_oe,
	input wire logic bus_driven_n
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	// A start the device takes: granted away and idle
	sequence start_s;
		!transfer_start_n && bus_granted_away_i && !busy_o;
	endsequence
	// Negated acknowledge for one cycle, then released
	sequence ack_end_s;
		transfer_ack_n && transfer_ack_n_oe ##1 !transfer_ack_n_oe;
	endsequence
	strobe_grant_a: assert property ((cs_n != 8'hFF || ras_n != 2'h3) |-> bus_granted_away_i)
		else $error("strobe while bus not given away");
	accept_busy_a: assert property (start_s |=> busy_o)
		else $error("start not taken");
	ack_start_a: assert property ($rose(transfer_ack_n_oe) |-> !$past(transfer_start_n, 2))
		else $error("acknowledge driven without decode clock");
	ack_bound_a: assert property (start_s ##2 transfer_ack_n_oe |-> ##[0:15] !transfer_ack_n)
		else $error("acknowledge missing after wait count");
	ack_pulse_a: assert property ($fell(transfer_ack_n) |=> ack_end_s)
		else $error("acknowledge not negated then released");
	no_addr_a: assert property (cs_n != 8'hFF |-> !dram_addr_oe)
		else $error("address driven on chip select access");
	long_we_a: assert property (start_s and !rd_wr && transfer_size == 2'h0 |-> ##2 (we_n == 4'h0 || cs_n == 8'hFF))
		else $error("long write enables wrong");
	driven_a: assert property (!$past(srst_i) |-> bus_driven_n == !$past(explicit_own_i))
		else $error("bus driven output wrong");
	wdata_hold_a: assert property (!transfer_ack_n && !rd_wr |-> wdata_oe ##2 !wdata_oe)
		else $error("write data not held then released");
endmodule

// ---- bench/tb_external_master_access_decoder.sv ----
// Testbench joining the decoder end and the outside master end
`timescale 1ns/1ps
module tb_external_master_access_decoder;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic granted = 1'b1, own = 1'b0, hi = 1'b0, access_type_mode = 1'b0, req = 1'b0, rd = 1'b0, done;
	logic [1:0] ttype = 2'h0, size = 2'h0, s_ras, s_ras_q;
	logic [27:0] addr = 28'h0;
	logic [31:0] wdata = 32'h0, rbus = 32'h0, rdata, s_wd;
	logic [7:0] cs_base [8] = '{8'h01, 8'h03, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
	logic [3:0] cs_wait [8] = '{4'h2, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
	logic [7:0] dram_base [2] = '{8'h02, 8'h04};
	logic [7:0] s_cs;
	logic [3:0] s_we, s_cas;
	logic s_dw, s_dao;
	logic [27:0] s_da;
	logic dbusy;
	// Memory map settings that scenarios change on the fly
	logic [7:0] cs_wr = 8'h01, cs_aa = 8'hFF;
	logic [1:0] dram_wr = 2'h1;
	logic [3:0] dram_wt = 4'h1, dflt_wt = 4'h3;
	logic dflt_aa = 1'b1;
	int fail_count = 0, n_checks = 0, cyc = 0, cnt = 0, lat = 0;
	emad_bus_if bus();
	always #2.5 mclk_i = ~mclk_i;
	emad_device i_emad_device (.mclk_i(mclk_i), .srst_i(srst_i), .bus_granted_away_i(granted),
		.explicit_own_i(own), .hi_addr_is_addr_i(hi), .cs_base_i(cs_base),
		.cs_enable_i(8'h03), .cs_rd_en_i(8'h03), .cs_wr_en_i(cs_wr), .cs_auto_ack_i(cs_aa),
		.cs_wait_i(cs_wait), .dram_bank_en_i(2'h1), .dram_rd_en_i(2'h1), .dram_wr_en_i(dram_wr),
		.dram_base_i(dram_base), .dram_wait_i(dram_wt), .default_auto_ack_i(dflt_aa),
		.default_wait_i(dflt_wt), .transfer_type_i(ttype), .access_type_mode_i(access_type_mode), .bus(bus),
		.busy_o(dbusy));
	emad_master i_emad_master (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req), .req_rd_i(rd),
		.req_size_i(size), .req_addr_i(addr), .req_wdata_i(wdata), .rdata_bus_i(rbus),
		.done_o(done), .rdata_o(rdata), .busy_o(), .bus(bus));
	emad_asserts i_emad_asserts (.mclk_i(mclk_i), .srst_i(srst_i), .bus_granted_away_i(granted),
		.explicit_own_i(own), .busy_o(dbusy), .transfer_start_n(bus.transfer_start_n),
		.rd_wr(bus.rd_wr), .transfer_size(bus.transfer_size), .wdata_oe(bus.wdata_oe),
		.transfer_ack_n(bus.transfer_ack_n), .transfer_ack_n_oe(bus.transfer_ack_n_oe),
		.cs_n(bus.cs_n), .we_n(bus.we_n), .ras_n(bus.ras_n), .dram_addr_oe(bus.dram_addr_oe),
		.bus_driven_n(bus.bus_driven_n));
	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (!ok)
		begin
			fail_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Snapshot at the acknowledge; latency counts from the start edge
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fail_count++;
			results();
		end
		cnt <= (bus.transfer_start_n === 1'b0) ? 0 : cnt + 1;
		if (bus.transfer_ack_n === 1'b0)
		begin
			lat <= cnt + 1;
			s_cs <= bus.cs_n;
			s_we <= bus.we_n;
			s_ras <= bus.ras_n;
			s_cas <= bus.cas_n;
			s_wd <= bus.wdata;
			s_dw <= bus.dram_write_n;
			s_dao <= bus.dram_addr_oe;
			s_da <= bus.dram_addr;
		end
	end
	// One transfer; request held until done, bounded wait
	task automatic xfer(input logic r, input logic [1:0] sz, input logic [27:0] a,
		input logic [7:0] ecs, input logic [1:0] eras, input logic [3:0] ewe,
		input logic [3:0] ecas, input int elat);
		int w;
		logic dok;
		w = 0;
		@(posedge mclk_i);
		rd <= r;
		size <= sz;
		addr <= a;
		wdata <= {4'h5, a};
		rbus <= {4'hA, a};
		ttype <= ttype + 2'h1;
		access_type_mode <= ~access_type_mode;
		req <= 1'b1;
		while (done !== 1'b1 && w < 40)
		begin
			@(posedge mclk_i);
			w++;
		end
		req <= 1'b0;
		chk(done === 1'b1, "no completion");
		chk(lat === elat, "acknowledge latency");
		chk(s_cs === ecs && s_we === ewe, "chip select strobes");
		chk(s_ras === eras && s_cas === ecas, "dram strobes");
		// Address is driven only for DRAM hits; write strobe low only on DRAM writes
		dok = (s_dao === (eras != 2'h3)) && (s_dw === (eras == 2'h3 || r));
		chk(dok && (eras == 2'h3 || s_da === a), "dram address and direction");
		if (r)
			chk(rdata === {4'hA, a}, "read data");
		else
			chk(s_wd === {4'h5, a}, "write data");
		$display("test done at %h", a);
	endtask
	// Start that must go unacknowledged; the stuck master is then freed by a reset
	task automatic no_ack(input logic g, input logic [27:0] a, input logic [7:0] ecs,
		input int eseen);
		int seen, bad;
		seen = 0;
		bad = 0;
		@(posedge mclk_i);
		granted <= g;
		rd <= 1'b1;
		size <= 2'h0;
		addr <= a;
		req <= 1'b1;
		repeat (20)
		begin
			@(posedge mclk_i);
			if (bus.cs_n === ecs && bus.ras_n === 2'h3)
				seen++;
			else if (bus.cs_n !== 8'hFF || bus.ras_n !== 2'h3)
				bad++;
			if (bus.transfer_ack_n !== 1'b1 || done !== 1'b0)
				bad++;
		end
		chk(bad == 0 && seen == eseen, "unexpected strobe or acknowledge");
		req <= 1'b0;
		srst_i <= 1'b1;
		granted <= 1'b1;
		repeat (4) @(posedge mclk_i);
		srst_i <= 1'b0;
		$display("test done without acknowledge at %h", a);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (4) @(posedge mclk_i);
		srst_i <= 1'b0;
		own <= 1'b1;
		repeat (2) @(posedge mclk_i);
		chk(bus.bus_driven_n === 1'b0, "bus driven");
		own <= 1'b0;
		repeat (2) @(posedge mclk_i);
		xfer(1'b1, 2'h0, 28'hA100000, 8'hFE, 2'h3, 4'hF, 4'hF, 4);
		xfer(1'b0, 2'h1, 28'h0100001, 8'hFE, 2'h3, 4'hB, 4'hF, 4);
		xfer(1'b0, 2'h2, 28'h0100002, 8'hFE, 2'h3, 4'hC, 4'hF, 4);
		xfer(1'b0, 2'h0, 28'h0100000, 8'hFE, 2'h3, 4'h0, 4'hF, 4);
		xfer(1'b0, 2'h0, 28'h0300000, 8'hFF, 2'h3, 4'hF, 4'hF, 5);
		xfer(1'b1, 2'h0, 28'h0300000, 8'hFD, 2'h3, 4'hF, 4'hF, 2);
		cs_wr <= 8'h03;
		xfer(1'b0, 2'h0, 28'h0300000, 8'hFD, 2'h3, 4'h0, 4'hF, 2);
		xfer(1'b1, 2'h0, 28'h0200000, 8'hFF, 2'h2, 4'hF, 4'h0, 3);
		dram_wt <= 4'h2;
		xfer(1'b0, 2'h2, 28'h0200002, 8'hFF, 2'h2, 4'hF, 4'hC, 4);
		// Bank not write-enabled: the write falls through to default memory
		dram_wr <= 2'h0;
		xfer(1'b0, 2'h2, 28'h0200002, 8'hFF, 2'h3, 4'hF, 4'hF, 5);
		dflt_wt <= 4'h0;
		xfer(1'b1, 2'h1, 28'h0600003, 8'hFF, 2'h3, 4'hF, 4'hF, 2);
		dflt_wt <= 4'h3;
		hi <= 1'b1;
		xfer(1'b1, 2'h0, 28'hA100000, 8'hFF, 2'h3, 4'hF, 4'hF, 5);
		// Bus not given away: a start draws nothing, as if start were gated off
		no_ack(1'b0, 28'h0100000, 8'hFF, 20);
		// Auto-acknowledge off: one chip-select strobe cycle, no strobes from default memory, acknowledge never driven
		cs_aa <= 8'hFD;
		no_ack(1'b1, 28'h0300000, 8'hFD, 1);
		cs_aa <= 8'hFF;
		dflt_aa <= 1'b0;
		no_ack(1'b1, 28'h0600000, 8'hFF, 20);
		dflt_aa <= 1'b1;
		dflt_wt <= 4'h5;
		xfer(1'b1, 2'h0, 28'h0500000, 8'hFF, 2'h3, 4'hF, 4'hF, 7);
		results();
	end
endmodule

// ---- hw/emad_bus_if.sv ----
// Interface joining the decoder end and the outside master end
`timescale 1ns/1ps
interface emad_bus_if;
	// Master to device
	logic transfer_start_n;
	logic rd_wr;
	logic [1:0] transfer_size;
	logic [27:0] addr;
	logic [31:0] wdata;
	logic wdata_oe;
	// Device to master and memories
	logic transfer_ack_n_o;
	logic transfer_ack_n_oe;
	logic [7:0] cs_n;
	logic [3:0] we_n;
	logic [1:0] ras_n;
	logic [3:0] cas_n;
	logic dram_write_n;
	logic [27:0] dram_addr;
	logic dram_addr_oe;
	logic bus_driven_n;
	// Resolved acknowledge wire: pulled high when undriven
	logic transfer_ack_n;
	assign transfer_ack_n = transfer_ack_n_oe ? transfer_ack_n_o : 1'b1;
	modport dev (
		input transfer_start_n, rd_wr, transfer_size, addr,
		output transfer_ack_n_o, transfer_ack_n_oe, cs_n, we_n, ras_n, cas_n,
		output dram_write_n, dram_addr, dram_addr_oe, bus_driven_n
	);
	modport mst (
		output transfer_start_n, rd_wr, transfer_size, addr, wdata, wdata_oe,
		input transfer_ack_n, bus_driven_n
	);
endinterface

// ---- hw/emad_device.sv ----
// Device end: snoops outside master transfers and serves strobes and acknowledge
// Behaviour
// - Strobes only when granted away and started
// - Capture address, direction, size on start
// - Zero top address bits when pins repurposed
// - Ignore type and privilege mask inputs
// - Master issues only aligned transfers
// - Keep start negated when strobes unwanted (master still drives start; device ignores it unless granted away)
// - Drive memory sequence on next edge
// - Chip-select hit: select and write enables
// - Chip-select auto-acknowledge when option set
// - Never drive address for chip-select/default
// - DRAM hit: row, column, address, acknowledge
// - Default memory: acknowledge after wait states
// - One extra decode clock before counter
// - Master drives address, size, direction, start
// - Master negates start, drives write data
// - Zero waits: acknowledge at third clock
// - Nonzero waits: drive negated acknowledge first
// - Master samples acknowledge until asserted
// - Master holds write data while waiting
// - Drive acknowledge negated, then release
// - Master releases data after write
// - Bus driven only in explicit ownership
`timescale 1ns/1ps
module emad_device
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Arbitration state from the surrounding unit
	input wire logic bus_granted_away_i,
	input wire logic explicit_own_i,
	// Memory map settings
	input wire logic hi_addr_is_addr_i,
	input wire logic [7:0] cs_base_i [8],
	input wire logic [7:0] cs_enable_i,
	input wire logic [7:0] cs_rd_en_i,
	input wire logic [7:0] cs_wr_en_i,
	input wire logic [7:0] cs_auto_ack_i,
	input wire logic [3:0] cs_wait_i [8],
	input wire logic [1:0] dram_bank_en_i,
	input wire logic [1:0] dram_rd_en_i,
	input wire logic [1:0] dram_wr_en_i,
	input wire logic [7:0] dram_base_i [2],
	input wire logic [3:0] dram_wait_i,
	input wire logic default_auto_ack_i,
	input wire logic [3:0] default_wait_i,
	// Ignored during outside transfers
	input wire logic [1:0] transfer_type_i,
	input wire logic access_type_mode_i,
	// Link to the master
	emad_bus_if.dev bus,
	// Status
	output logic busy_o
);
	// ****************************************
	// State
	// ****************************************
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_DECODE = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_END = 4'b1000
	} emad_state_e;

	typedef struct packed
	{
		emad_state_e st;
		logic [27:0] addr;
		logic rd;
		logic [1:0] size;
		logic [3:0] wcnt;
		logic auto_ack;
		logic [7:0] cs_n;
		logic [3:0] we_n;
		logic [1:0] ras_n;
		logic [3:0] cas_n;
		logic dram_write_n;
		logic [27:0] dram_addr;
		logic dram_addr_oe;
		logic ack_n;
		logic ack_oe;
		logic release_ack;
		logic bd_n;
		logic busy;
	} emad_state_s;

	emad_state_s state_reg;
	emad_state_s state_next;

	// ****************************************
	// Address decode of the captured transfer
	// ****************************************
	logic [7:0] cs_hit;
	logic [1:0] dram_hit;
	logic [3:0] byte_we_n;
	logic [3:0] sel_wait;
	logic sel_ack;
	logic any_cs;
	logic any_dram;
	logic dir_ok_cs;
	logic dir_ok_dram;

	// Region match compares top address byte only; privilege masks play no part
	genvar gi;
	generate
		for (gi = 0; gi < emad_pkg::CS_N; gi++)
		begin : g_cs
			assign cs_hit[gi] = cs_enable_i[gi]
				&& (state_reg.addr[27:20] == cs_base_i[gi])
				&& (state_reg.rd ? cs_rd_en_i[gi] : cs_wr_en_i[gi]);
		end
		for (gi = 0; gi < 2; gi++)
		begin : g_dram
			assign dram_hit[gi] = dram_bank_en_i[gi]
				&& (state_reg.addr[27:20] == dram_base_i[gi])
				&& (state_reg.rd ? dram_rd_en_i[gi] : dram_wr_en_i[gi]);
		end
	endgenerate

	// Byte enables from size and low address; aligned transfers assumed
	always_comb
	begin
		case (state_reg.size)
			emad_pkg::SIZE_BYTE: byte_we_n = ~(4'h8 >> state_reg.addr[1:0]);
			emad_pkg::SIZE_WORD: byte_we_n = state_reg.addr[1] ? 4'hC : 4'h3;
			default: byte_we_n = 4'h0;
		endcase
	end

	// Priority: chip-select over DRAM over default memory
	always_comb
	begin
		any_cs = |cs_hit;
		any_dram = |dram_hit;
		dir_ok_cs = any_cs;
		dir_ok_dram = any_dram;
		sel_wait = default_wait_i;
		sel_ack = default_auto_ack_i;
		if (any_dram)
		begin
			sel_wait = dram_wait_i;
			sel_ack = 1'b1;
		end
		for (int i = emad_pkg::CS_N - 1; i >= 0; i--)
		begin
			if (cs_hit[i])
			begin
				sel_wait = cs_wait_i[i];
				sel_ack = cs_auto_ack_i[i];
			end
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		state_next.bd_n = ~explicit_own_i;
		case (state_reg.st)
			ST_IDLE:
			begin
				state_next.ack_oe = 1'b0;
				state_next.ack_n = 1'b1;
				// Start is honoured only while the bus belongs to another master
				if (bus_granted_away_i && !bus.transfer_start_n)
				begin
					state_next.addr = bus.addr;
					if (!hi_addr_is_addr_i)
						state_next.addr[27:24] = emad_pkg::HI_ADDR_ZERO;
					state_next.rd = bus.rd_wr;
					state_next.size = bus.transfer_size;
					state_next.busy = 1'b1;
					state_next.st = ST_DECODE;
				end
			end
			ST_DECODE:
			begin
				// Extra decode clock; strobes start at the next edge
				state_next.wcnt = sel_wait;
				state_next.auto_ack = sel_ack;
				if (dir_ok_cs)
				begin
					state_next.cs_n = ~cs_hit;
					state_next.we_n = state_reg.rd ? 4'hF : byte_we_n;
				end
				else if (dir_ok_dram)
				begin
					state_next.ras_n = ~dram_hit;
					state_next.cas_n = byte_we_n;
					state_next.dram_write_n = state_reg.rd;
					state_next.dram_addr = state_reg.addr;
					state_next.dram_addr_oe = 1'b1;
				end
				// Default and chip-select decodes leave the address bus alone
				if (sel_ack)
				begin
					state_next.ack_oe = 1'b1;
					state_next.ack_n = (sel_wait != emad_pkg::WS_ZERO);
				end
				state_next.st = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (!state_reg.ack_n || state_reg.wcnt == emad_pkg::WS_ZERO)
				begin
					// Acknowledge taken or wait count run out this edge: negate everything
					state_next.ack_n = 1'b1;
					state_next.cs_n = 8'hFF;
					state_next.we_n = 4'hF;
					state_next.ras_n = 2'h3;
					state_next.cas_n = 4'hF;
					state_next.dram_write_n = 1'b1;
					state_next.dram_addr_oe = 1'b0;
					state_next.st = ST_END;
				end
				else
				begin
					state_next.wcnt = state_reg.wcnt - 4'h1;
					if (state_reg.wcnt == 4'h1)
						state_next.ack_n = ~state_reg.auto_ack;
				end
			end
			ST_END:
			begin
				// One negated cycle done, release acknowledge to float
				state_next.ack_oe = 1'b0;
				state_next.busy = 1'b0;
				state_next.st = ST_IDLE;
			end
			default:
				state_next.st = ST_IDLE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			state_reg <= '0;
			state_reg.st <= ST_IDLE;
			state_reg.cs_n <= 8'hFF;
			state_reg.we_n <= 4'hF;
			state_reg.ras_n <= 2'h3;
			state_reg.cas_n <= 4'hF;
			state_reg.dram_write_n <= 1'b1;
			state_reg.ack_n <= 1'b1;
			state_reg.bd_n <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	// Outputs straight from flip-flops
	assign bus.transfer_ack_n_o = state_reg.ack_n;
	assign bus.transfer_ack_n_oe = state_reg.ack_oe;
	assign bus.cs_n = state_reg.cs_n;
	assign bus.we_n = state_reg.we_n;
	assign bus.ras_n = state_reg.ras_n;
	assign bus.cas_n = state_reg.cas_n;
	assign bus.dram_write_n = state_reg.dram_write_n;
	assign bus.dram_addr = state_reg.dram_addr;
	assign bus.dram_addr_oe = state_reg.dram_addr_oe;
	assign bus.bus_driven_n = state_reg.bd_n;
	assign busy_o = state_reg.busy;
endmodule

// ---- hw/emad_master.sv ----
// Outside master end: issues single transfers and waits for the acknowledge
`timescale 1ns/1ps
module emad_master
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// User request
	input wire logic req_i,
	input wire logic req_rd_i,
	input wire logic [1:0] req_size_i,
	input wire logic [27:0] req_addr_i,
	input wire logic [31:0] req_wdata_i,
	input wire logic [31:0] rdata_bus_i,
	// User answer
	output logic done_o,
	output logic [31:0] rdata_o,
	output logic busy_o,
	// Link
	emad_bus_if.mst bus
);
	// ****************************************
	// State
	// ****************************************
	typedef enum logic [3:0]
	{
		MS_IDLE = 4'b0001,
		MS_START = 4'b0010,
		MS_WAIT = 4'b0100,
		MS_END = 4'b1000
	} emad_mstate_e;

	typedef struct packed
	{
		emad_mstate_e st;
		logic ts_n;
		logic rd;
		logic [1:0] size;
		logic [27:0] addr;
		logic [31:0] wdata;
		logic wdata_oe;
		logic done;
		logic [31:0] rdata;
		logic busy;
	} emad_mstate_s;

	emad_mstate_s state_reg;
	emad_mstate_s state_next;

	// Next state
	always_comb
	begin
		state_next = state_reg;
		state_next.done = 1'b0;
		case (state_reg.st)
			MS_IDLE:
			begin
				// Held off while the device owns the bus; request is taken only when free
				if (req_i && bus.bus_driven_n)
				begin
					// Aligned address, size, direction and start together
					state_next.addr = req_addr_i;
					state_next.rd = req_rd_i;
					state_next.size = req_size_i;
					state_next.wdata = req_wdata_i;
					state_next.ts_n = 1'b0;
					state_next.busy = 1'b1;
					state_next.st = MS_START;
				end
			end
			MS_START:
			begin
				state_next.ts_n = 1'b1;
				state_next.wdata_oe = ~state_reg.rd;
				state_next.st = MS_WAIT;
			end
			MS_WAIT:
			begin
				// Sample acknowledge each edge; write data held meanwhile
				if (!bus.transfer_ack_n)
				begin
					state_next.rdata = state_reg.rd ? rdata_bus_i : state_reg.rdata;
					state_next.done = 1'b1;
					state_next.st = MS_END;
				end
			end
			MS_END:
			begin
				state_next.wdata_oe = 1'b0;
				state_next.busy = 1'b0;
				state_next.st = MS_IDLE;
			end
			default:
				state_next.st = MS_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			state_reg <= '0;
			state_reg.st <= MS_IDLE;
			state_reg.ts_n <= 1'b1;
			state_reg.rd <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	assign bus.transfer_start_n = state_reg.ts_n;
	assign bus.rd_wr = state_reg.rd;
	assign bus.transfer_size = state_reg.size;
	assign bus.addr = state_reg.addr;
	assign bus.wdata = state_reg.wdata;
	assign bus.wdata_oe = state_reg.wdata_oe;
	assign done_o = state_reg.done;
	assign rdata_o = state_reg.rdata;
	assign busy_o = state_reg.busy;
endmodule

// ---- hw/emad_pkg.sv ----
// Package with shared constants for the external master access decoder
package emad_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W = 28;
	localparam int DATA_W = 32;
	localparam int CS_N = 8;
	localparam int WS_W = 4;
	localparam int HI_ADDR_LSB = 24;
	localparam int CS_REGION_LSB = 16;
	// ****************************************
	// Values after reset and fixed codes
	// ****************************************
	localparam logic [WS_W-1:0] WS_ZERO = 4'h0;
	localparam logic [3:0] HI_ADDR_ZERO = 4'h0;
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	// Master holds write data this many cycles after the acknowledge before release
	localparam logic [1:0] MST_RELEASE_CYC = 2'h1;
endpackage
